/* File: pmcs_pkg.sv */
/*
  Package for the port MAC configuration and status block: register
  indices, field widths, reset values, timing constants and carrier types.
  Assumes a register access port that presents the register index directly.
*/
package pmcs_pkg;

  localparam int unsigned PMCS_ADDR_W = 8;
  localparam int unsigned PMCS_DATA_W = 32;

  // Register indices as the host addresses them.
  localparam logic [7:0] PMCS_IDX_RX_LEN_ERR_CNT = 8'ha6;
  localparam logic [7:0] PMCS_IDX_RX_GAP_ERR_CNT = 8'hae;
  localparam logic [7:0] PMCS_IDX_TX_GAP = 8'hb0;
  localparam logic [7:0] PMCS_IDX_LOOPBACK = 8'hb3;
  localparam logic [7:0] PMCS_IDX_RX_CRC = 8'hb4;
  localparam logic [7:0] PMCS_IDX_RX_GAP = 8'hb5;
  localparam logic [7:0] PMCS_IDX_RX_MAX_LEN = 8'hb6;
  localparam logic [7:0] PMCS_IDX_RX_MIN_LEN = 8'hb7;
  localparam logic [7:0] PMCS_IDX_LO_FRAMES = 8'hb8;
  localparam logic [7:0] PMCS_IDX_HI_FRAMES = 8'hb9;
  localparam logic [7:0] PMCS_IDX_LO_FILL = 8'hba;
  localparam logic [7:0] PMCS_IDX_HI_FILL = 8'hbb;
  localparam logic [7:0] PMCS_IDX_FWD_FILL = 8'hbc;

  // Reset values of the writable fields.
  localparam logic [7:0] PMCS_RST_TX_GAP = 8'h0b;
  localparam logic PMCS_RST_LOOPBACK = 1'b0;
  localparam logic PMCS_RST_CRC_EN = 1'b1;
  localparam logic [5:0] PMCS_RST_RX_GAP = 6'h0a;
  localparam logic [15:0] PMCS_RST_MAX_LEN = 16'h0618;
  localparam logic [15:0] PMCS_RST_MIN_LEN = 16'h0040;

  // Timing: one MII nibble per clock, so eight bit times take two clocks.
  localparam int unsigned PMCS_BITS_PER_NIBBLE = 4;
  localparam int unsigned PMCS_GAP_UNIT_BITS = 8;
  localparam int unsigned PMCS_CYC_PER_GAP_UNIT = PMCS_GAP_UNIT_BITS / PMCS_BITS_PER_NIBBLE;

  // Frame markers and check values.
  localparam logic [3:0] PMCS_SFD_NIBBLE = 4'hd;
  localparam logic [31:0] PMCS_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] PMCS_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] PMCS_CRC_RESIDUE = 32'hdebb20e3;

  typedef struct packed {
    logic [8:0] low_frames;
    logic [8:0] high_frames;
    logic [13:0] low_halfwords;
    logic [13:0] high_halfwords;
    logic [13:0] fwd_halfwords;
  } pmcs_queue_stat_t;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } pmcs_mii_t;

  typedef enum logic [1:0] {
    PMCS_TX_IDLE = 2'b00,
    PMCS_TX_SEND = 2'b01,
    PMCS_TX_GAP = 2'b10
  } pmcs_tx_state_t;

endpackage

/* File: pmcs_port_mac.sv */
/*
  Configuration and status logic of one switch port MAC: transmit gap
  pacing, MII loopback, receive gap, length and CRC checks with gap and length
  error counters, and the queue status registers.
  Assumes the host register port, the transmit source and the queue status
  run on clk; the MII receive pins come from the PHY and are synchronised.
*/
// Functional notes
// - Transmit gap is (gap value plus one) times eight bit times; resets to eleven.
// - Loopback bit set loops MII traffic back; cleared by default for normal operation.
// - Receive CRC is checked only while the enable bit is set; resets to one.
// - Received gaps must exceed the six-bit gap value times eight bit times.
// - A too-short received gap drops the frame and raises the gap error flag.
// - Sixteen-bit maximum receive frame length in bytes, resetting to 1560.
// - Sixteen-bit minimum receive frame length in bytes, resetting to 64.
// - Read-only nine-bit count of frames in the low priority queue.
// - Read-only nine-bit count of frames in the high priority queue.
// - Read-only fourteen-bit half word fill of the low priority queue.
// - Read-only fourteen-bit half word fill of the high priority queue.
// - Read-only fourteen-bit half word fill of the forwarding transmit queue.
// - Thirty-two-bit counter of received frames failing the gap check.
// - Thirty-two-bit counter of received frames that pass the gap check but are too long or too short.
module pmcs_port_mac
  import pmcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PMCS_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [PMCS_DATA_W-1:0] reg_wdata,
  output logic [PMCS_DATA_W-1:0] reg_rdata_q,
  input wire logic tx_valid,
  input wire logic [3:0] tx_nibble,
  output logic tx_ready_q,
  output logic mii_tx_en_q,
  output logic [3:0] mii_txd_q,
  input wire logic mii_rx_dv,
  input wire logic [3:0] mii_rxd,
  output logic rx_frame_good_q,
  output logic rx_frame_bad_q,
  output logic rx_gap_error_flag_q,
  input wire pmcs_queue_stat_t queue_stat,
  output logic rx_frame_available_q
);

  function automatic logic [31:0] crc_nibble(input logic [31:0] crc, input logic [3:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 4; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ PMCS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  logic [7:0] tx_gap_value_q;
  logic mii_loop_enable_q;
  logic rx_crc_check_enable_q;
  logic [5:0] rx_gap_min_value_q;
  logic [15:0] rx_length_ceiling_q;
  logic [15:0] rx_length_floor_q;
  logic [31:0] rx_gap_error_counter_q;
  logic [31:0] rx_length_error_counter_q;
  pmcs_queue_stat_t stat_q;

  // Configuration writes; only the field bits are stored.
  // limits stored, reserved dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_gap_value_q <= PMCS_RST_TX_GAP;
      mii_loop_enable_q <= PMCS_RST_LOOPBACK;
      rx_crc_check_enable_q <= PMCS_RST_CRC_EN;
      rx_gap_min_value_q <= PMCS_RST_RX_GAP;
      rx_length_ceiling_q <= PMCS_RST_MAX_LEN;
      rx_length_floor_q <= PMCS_RST_MIN_LEN;
    end else if (reg_wr) begin
      unique case (reg_addr)
        PMCS_IDX_TX_GAP: tx_gap_value_q <= reg_wdata[7:0];
        PMCS_IDX_LOOPBACK: mii_loop_enable_q <= reg_wdata[0];
        PMCS_IDX_RX_CRC: rx_crc_check_enable_q <= reg_wdata[0];
        PMCS_IDX_RX_GAP: rx_gap_min_value_q <= reg_wdata[5:0];
        PMCS_IDX_RX_MAX_LEN: rx_length_ceiling_q <= reg_wdata[15:0];
        PMCS_IDX_RX_MIN_LEN: rx_length_floor_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Status is sampled every clock so a host read sees a coherent snapshot per register.
  // queue status capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
      rx_frame_available_q <= 1'b0;
    end else begin
      stat_q <= queue_stat;
      rx_frame_available_q <= (queue_stat.low_frames != 9'h000)
        || (queue_stat.high_frames != 9'h000);
    end
  end

  // Read data is returned on the clock after the read strobe.
  // register read map: configuration fields and read-only status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        PMCS_IDX_RX_LEN_ERR_CNT: reg_rdata_q <= rx_length_error_counter_q;
        PMCS_IDX_RX_GAP_ERR_CNT: reg_rdata_q <= rx_gap_error_counter_q;
        PMCS_IDX_TX_GAP: reg_rdata_q <= {24'h000000, tx_gap_value_q};
        PMCS_IDX_LOOPBACK: reg_rdata_q <= {31'h00000000, mii_loop_enable_q};
        PMCS_IDX_RX_CRC: reg_rdata_q <= {31'h00000000, rx_crc_check_enable_q};
        PMCS_IDX_RX_GAP: reg_rdata_q <= {26'h0000000, rx_gap_min_value_q};
        PMCS_IDX_RX_MAX_LEN: reg_rdata_q <= {16'h0000, rx_length_ceiling_q};
        PMCS_IDX_RX_MIN_LEN: reg_rdata_q <= {16'h0000, rx_length_floor_q};
        PMCS_IDX_LO_FRAMES: reg_rdata_q <= {23'h000000, stat_q.low_frames};
        PMCS_IDX_HI_FRAMES: reg_rdata_q <= {23'h000000, stat_q.high_frames};
        PMCS_IDX_LO_FILL: reg_rdata_q <= {18'h00000, stat_q.low_halfwords};
        PMCS_IDX_HI_FILL: reg_rdata_q <= {18'h00000, stat_q.high_halfwords};
        PMCS_IDX_FWD_FILL: reg_rdata_q <= {18'h00000, stat_q.fwd_halfwords};
        default: reg_rdata_q <= '0;
      endcase
    end
  end

  // Transmit pacing. The source must hold tx_valid without gaps for a frame,
  // as MII cannot pause mid-frame; dropping tx_valid ends the frame.
  pmcs_tx_state_t tx_state_q;
  logic [8:0] tx_gap_cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_q <= PMCS_TX_IDLE;
      tx_gap_cnt_q <= '0;
      tx_ready_q <= 1'b1;
      mii_tx_en_q <= 1'b0;
      mii_txd_q <= 4'h0;
    end else begin
      unique case (tx_state_q)
        PMCS_TX_IDLE: begin
          mii_tx_en_q <= tx_valid;
          mii_txd_q <= tx_valid ? tx_nibble : 4'h0;
          if (tx_valid) begin
            tx_state_q <= PMCS_TX_SEND;
          end
        end
        PMCS_TX_SEND: begin
          mii_tx_en_q <= tx_valid;
          mii_txd_q <= tx_valid ? tx_nibble : 4'h0;
          if (!tx_valid) begin
            // The gap is (value+1)*2 clocks; two of them pass in the hand-off.
            tx_gap_cnt_q <= {tx_gap_value_q, 1'b0};
            tx_ready_q <= 1'b0;
            tx_state_q <= PMCS_TX_GAP;
          end
        end
        PMCS_TX_GAP: begin
          if (tx_gap_cnt_q == 9'h000) begin
            tx_ready_q <= 1'b1;
            tx_state_q <= PMCS_TX_IDLE;
          end else begin
            tx_gap_cnt_q <= tx_gap_cnt_q - 9'h001;
          end
        end
        default: begin
          tx_state_q <= PMCS_TX_IDLE;
          tx_ready_q <= 1'b1;
          mii_tx_en_q <= 1'b0;
        end
      endcase
    end
  end

  // The PHY's receive pins are asynchronous to clk.
  pmcs_mii_t rx_s1_q;
  pmcs_mii_t rx_s2_q;
  pmcs_mii_t rx_src;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1_q <= '0;
      rx_s2_q <= '0;
    end else begin
      rx_s1_q <= '{en: mii_rx_dv, data: mii_rxd};
      rx_s2_q <= rx_s1_q;
    end
  end

  always_comb begin
    rx_src = mii_loop_enable_q ? pmcs_mii_t'{en: mii_tx_en_q, data: mii_txd_q} : rx_s2_q;
  end

  logic rx_active_q;
  logic [7:0] rx_idle_q;
  logic rx_gap_short_q;
  logic rx_sfd_q;
  logic [17:0] rx_nib_q;
  logic [31:0] rx_crc_q;
  logic rx_end;
  logic [16:0] rx_bytes;
  logic rx_len_err;
  logic rx_crc_err;
  logic [7:0] rx_gap_limit;

  always_comb begin
    rx_end = rx_active_q && !rx_src.en;
    rx_bytes = rx_nib_q[17:1];
    rx_gap_limit = {1'b0, rx_gap_min_value_q, 1'b0};
  end

  always_comb begin
    rx_len_err = (rx_bytes > {1'b0, rx_length_ceiling_q})
      || (rx_bytes < {1'b0, rx_length_floor_q});
  end

  always_comb begin
    rx_crc_err = rx_crc_check_enable_q && (rx_crc_q != PMCS_CRC_RESIDUE);
  end

  // Idle time is counted from reset saturated so the first frame never fails the gap check.
  // receive gap measure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_active_q <= 1'b0;
      rx_idle_q <= 8'hff;
      rx_gap_short_q <= 1'b0;
    end else begin
      rx_active_q <= rx_src.en;
      if (rx_src.en) begin
        rx_idle_q <= 8'h00;
      end else if (rx_idle_q != 8'hff) begin
        rx_idle_q <= rx_idle_q + 8'h01;
      end
      if (rx_src.en && !rx_active_q) begin
        rx_gap_short_q <= (rx_idle_q <= rx_gap_limit);
      end
    end
  end

  // Preamble nibbles are skipped; length and CRC cover the bytes after the SFD.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sfd_q <= 1'b0;
      rx_nib_q <= '0;
      rx_crc_q <= PMCS_CRC_INIT;
    end else if (rx_src.en) begin
      if (!rx_sfd_q) begin
        rx_sfd_q <= (rx_src.data == PMCS_SFD_NIBBLE);
      end else begin
        rx_crc_q <= crc_nibble(rx_crc_q, rx_src.data);
        if (rx_nib_q != 18'h3ffff) begin
          rx_nib_q <= rx_nib_q + 18'h00001;
        end
      end
    end else if (!rx_active_q) begin
      rx_sfd_q <= 1'b0;
      rx_nib_q <= '0;
      rx_crc_q <= PMCS_CRC_INIT;
    end
  end

  // Verdict at frame end: gap drop takes priority over length, then CRC.
  // gap drop verdict
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_frame_good_q <= 1'b0;
      rx_frame_bad_q <= 1'b0;
      rx_gap_error_flag_q <= 1'b0;
    end else begin
      rx_gap_error_flag_q <= rx_end && rx_gap_short_q;
      rx_frame_bad_q <= rx_end && (rx_gap_short_q || rx_len_err || rx_crc_err);
      rx_frame_good_q <= rx_end && !rx_gap_short_q && !rx_len_err && !rx_crc_err;
    end
  end

  // Counters wrap; they are not cleared on read.
  // gap error count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_gap_error_counter_q <= '0;
    end else if (rx_end && rx_gap_short_q) begin
      rx_gap_error_counter_q <= rx_gap_error_counter_q + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_length_error_counter_q <= '0;
    end else if (rx_end && !rx_gap_short_q && rx_len_err) begin
      rx_length_error_counter_q <= rx_length_error_counter_q + 32'h00000001;
    end
  end

  logic [9:0] tx_low_q;
  logic [9:0] tx_gap_need_q;

  // The need is latched while sending, as a gap write during a gap only affects the next one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_low_q <= 10'h3ff;
      tx_gap_need_q <= 10'h000;
    end else if (mii_tx_en_q) begin
      tx_low_q <= 10'h000;
      tx_gap_need_q <= ({2'b00, tx_gap_value_q} + 10'h001) << 1;
    end else if (tx_low_q != 10'h3ff) begin
      tx_low_q <= tx_low_q + 10'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_ends_gap_ok;
    rx_end && !rx_gap_short_q;
  endsequence

  sequence s_len_bad;
    rx_len_err;
  endsequence

  AST_TX_GAP: assert property ($rose(mii_tx_en_q) |-> tx_low_q >= tx_gap_need_q)
    else $error("Transmit gap shorter than programmed.");

  AST_TX_READY_HOLD: assert property ($fell(mii_tx_en_q) |-> !tx_ready_q ##1 !mii_tx_en_q)
    else $error("Transmit ready returned too early after a frame.");

  AST_LOOP_PATH: assert property (mii_loop_enable_q && mii_tx_en_q && !rx_active_q
    |=> rx_active_q)
    else $error("Looped transmit did not reach the receive path.");

  AST_CRC_OFF: assert property (s_frame_ends_gap_ok and !rx_len_err
    and !rx_crc_check_enable_q |=> rx_frame_good_q)
    else $error("Frame rejected while CRC check disabled.");

  AST_GAP_DROP: assert property (rx_end && rx_gap_short_q
    |=> rx_gap_error_flag_q && rx_frame_bad_q && !rx_frame_good_q)
    else $error("Short gap frame was not dropped.");

  AST_GAP_COUNT: assert property (rx_gap_error_flag_q
    |-> rx_gap_error_counter_q == $past(rx_gap_error_counter_q) + 32'h00000001)
    else $error("Gap error counter did not advance.");

  AST_LEN_DROP: assert property (s_frame_ends_gap_ok ##0 s_len_bad
    |=> rx_frame_bad_q && !rx_frame_good_q
    && rx_length_error_counter_q == $past(rx_length_error_counter_q) + 32'h00000001)
    else $error("Length error frame delivered or not counted.");

  AST_AVAIL: assert property (##1 rx_frame_available_q
    == (($past(queue_stat.low_frames) != 9'h000) || ($past(queue_stat.high_frames) != 9'h000)))
    else $error("Frame available does not match queue counts.");

  AST_RSV_ZERO: assert property (reg_rd && (reg_addr == PMCS_IDX_RX_GAP)
    |=> reg_rdata_q[31:6] == 26'h0000000 && reg_rdata_q[5:0] == rx_gap_min_value_q)
    else $error("Reserved bits of receive gap register not zero.");

endmodule // pmcs_port_mac

/* File: pmcs_phy_model.sv */
/*
  Behavioural PHY on the receive side of the port MAC: builds frames with
  preamble, start nibble and FCS, and plays them on the MII receive pins.
  Assumes the bench calls its tasks in step with clk.
*/
module pmcs_phy_model
  import pmcs_pkg::*;
(
  input wire logic clk,
  output logic mii_rx_dv,
  output logic [3:0] mii_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] nibs[$];

  initial begin
    mii_rx_dv = 1'b0;
    mii_rxd = 4'h0;
  end

  task automatic build(input int len, input bit good);
    logic [31:0] crc;
    logic [7:0] b;
    crc = PMCS_CRC_INIT;
    nibs = {};
    repeat (15) nibs.push_back(4'h5);
    nibs.push_back(PMCS_SFD_NIBBLE);
    for (int i = 0; i < len - 4; i++) begin
      b = 8'(i * 37 + len);
      nibs.push_back(b[3:0]);
      nibs.push_back(b[7:4]);
      for (int k = 0; k < 8; k++)
        crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? PMCS_CRC_POLY : 32'h0);
    end
    crc = ~crc ^ {31'h0, !good};
    for (int i = 0; i < 8; i++)
      nibs.push_back(crc[4*i +: 4]);
  endtask

  // Idle data toggles so a stale nibble is never taken for frame data.
  task automatic play(input int idle);
    repeat (idle) @(posedge clk) mii_rxd <= ~mii_rxd;
    foreach (nibs[i]) begin
      @(posedge clk);
      mii_rx_dv <= 1'b1;
      mii_rxd <= nibs[i];
    end
    @(posedge clk);
    mii_rx_dv <= 1'b0;
    mii_rxd <= ~nibs[nibs.size()-1];
  endtask
endmodule // pmcs_phy_model

/* File: tb_top.sv */
/*
  Self-checking bench of the port MAC block: registers, queue status,
  transmit pacing, receive checks and loopback.
  Assumes the package and the PHY model are compiled first.
*/
module tb_top
  import pmcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, reg_wr, reg_rd, tx_valid, tx_ready_q, mii_tx_en_q, mii_rx_dv;
  logic good_q, bad_q, gap_q, avail_q, exp_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, v, s_len, s_gcnt;
  logic [3:0] tx_nibble, mii_txd_q, mii_rxd, exp_nib;
  logic [15:0] rnd;
  pmcs_queue_stat_t qs, e;
  int failures, total_checks, cyc, idle_n, last_gap, n_good, n_bad, n_gap;
  int s_good, s_bad, s_gap, len, minl, maxl;
  bit ok, ce;
  logic [7:0] ra[13] = '{8'hb0, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba,
    8'hbb, 8'hbc, 8'ha6, 8'hae};
  logic [31:0] rv[6] = '{32'hb, 32'h0, 32'h1, 32'ha, 32'h618, 32'h40};
  logic [31:0] mk[6] = '{32'hff, 32'h1, 32'h1, 32'h3f, 32'hffff, 32'hffff};
  int cl[6] = '{16, 15, 32, 33, 20, 20};
  bit cok[6] = '{1, 1, 1, 1, 0, 0};

  pmcs_port_mac pmcs_port_mac_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .tx_valid(tx_valid), .tx_nibble(tx_nibble), .tx_ready_q(tx_ready_q),
    .mii_tx_en_q(mii_tx_en_q), .mii_txd_q(mii_txd_q), .mii_rx_dv(mii_rx_dv),
    .mii_rxd(mii_rxd), .rx_frame_good_q(good_q), .rx_frame_bad_q(bad_q),
    .rx_gap_error_flag_q(gap_q), .queue_stat(qs), .rx_frame_available_q(avail_q));
  pmcs_phy_model pmcs_phy_model_inst (.clk(clk), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic bit len_bad(input int l);
    return l < minl || l > maxl;
  endfunction
  function automatic bit exp_good(input int l, input bit k, input bit en);
    return !len_bad(l) && (k || !en);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask
  task automatic snap();
    s_good = n_good;
    s_bad = n_bad;
    s_gap = n_gap;
    rd(8'ha6, s_len);
    rd(8'hae, s_gcnt);
  endtask
  task automatic expect_rx(input int dg, input int db, input int dgp, input int dl);
    repeat (8) @(posedge clk);
    check(n_good - s_good, dg, "good pulses");
    check(n_bad - s_bad, db, "bad pulses");
    check(n_gap - s_gap, dgp, "gap flags");
    rd(8'ha6, v);
    check(v - s_len, dl, "length count");
    rd(8'hae, v);
    check(v - s_gcnt, dgp, "gap count");
  endtask
  // Queued nibbles advance only on accepted edges, so refused cycles never drop data; random nibbles change every edge.
  task automatic tx_frame(input int n, input bit from_q);
    int k;
    int w;
    k = 0;
    w = 0;
    while (k < n && w < 400) begin
      @(posedge clk);
      if (tx_valid && tx_ready_q) k++;
      w++;
      rnd = lfsr(rnd);
      tx_valid <= (k < n);
      tx_nibble <= (from_q && k < n) ? pmcs_phy_model_inst.nibs[k] : rnd[3:0];
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (!rst) begin
      n_good += good_q;
      n_bad += bad_q;
      n_gap += gap_q;
      if (exp_en || mii_tx_en_q) check(mii_tx_en_q, exp_en, "tx enable");
      if (exp_en) check(mii_txd_q, exp_nib, "tx data");
      if (mii_tx_en_q && idle_n > 0) last_gap = idle_n;
      idle_n = mii_tx_en_q ? 0 : idle_n + 1;
    end
    exp_en = tx_valid && tx_ready_q;
    exp_nib = tx_nibble;
    if (cyc > 20000) begin
      failures++;
      $display("BAD t=%0t run did not finish", $time);
      results();
    end
  end

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_valid = 1'b0;
    tx_nibble = 4'h0;
    qs = '0;
    rnd = 16'h13f0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], v);
      check(v, (i < 6) ? rv[i] : 32'h0, "reset value");
    end
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(ra[i], {rnd, ~rnd});
      rd(ra[i], v);
      check(v, {rnd, ~rnd} & mk[i], "field write");
    end
    foreach (ra[i]) if (i > 5) wr(ra[i], 32'hffffffff);
    wr(8'hc0, 32'hffffffff);
    foreach (ra[i]) if (i > 5) begin
      rd(ra[i], v);
      check(v, 32'h0, "read-only write");
    end
    rd(8'hc0, v);
    check(v, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr({1'b0, rnd[6:0]}, {rnd, rnd});
      rd({1'b0, rnd[14:8]}, v);
      check(v, 32'h0, "random unmapped read");
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      e = '0;
      if (i == 1) e.high_frames = 9'h001;
      if (i == 2) e = '{rnd[8:0], rnd[15:7], rnd[13:0], {rnd[5:0], rnd[15:8]}, ~rnd[13:0]};
      @(posedge clk);
      qs <= e;
      rd(8'hb8, v);
      check(v, 32'(e.low_frames), "low frames");
      rd(8'hb9, v);
      check(v, 32'(e.high_frames), "high frames");
      rd(8'hba, v);
      check(v, 32'(e.low_halfwords), "low fill");
      rd(8'hbb, v);
      check(v, 32'(e.high_halfwords), "high fill");
      rd(8'hbc, v);
      check(v, 32'(e.fwd_halfwords), "forward fill");
      check(avail_q, (e.low_frames != 0) || (e.high_frames != 0), "frame ready");
    end
    $display("test queue status done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      len = (i == 0) ? 0 : (i == 1) ? 11 : int'(rnd[3:0]);
      wr(8'hb0, 32'(len));
      tx_frame(8, 1'b0);
      tx_frame(6, 1'b0);
      repeat (3) @(posedge clk);
      check(last_gap, (len + 1) * 2, "tx gap");
    end
    $display("test tx gap done");
    minl = 16;
    maxl = 32;
    wr(8'hb3, 32'h0);
    wr(8'hb5, 32'h4);
    wr(8'hb6, 32'(maxl));
    wr(8'hb7, 32'(minl));
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      len = (i < 6) ? cl[i] : 12 + int'(rnd[4:0]);
      ok = (i < 6) ? cok[i] : rnd[5];
      ce = (i != 5);
      wr(8'hb4, 32'(ce));
      snap();
      pmcs_phy_model_inst.build(len, ok);
      pmcs_phy_model_inst.play(20);
      expect_rx(exp_good(len, ok, ce), !exp_good(len, ok, ce), 0, len_bad(len));
    end
    $display("test rx checks done");
    wr(8'hb4, 32'h1);
    snap();
    pmcs_phy_model_inst.build(20, 1'b1);
    pmcs_phy_model_inst.play(20);
    pmcs_phy_model_inst.play(7);
    pmcs_phy_model_inst.build(40, 1'b1);
    pmcs_phy_model_inst.play(7);
    pmcs_phy_model_inst.build(20, 1'b1);
    pmcs_phy_model_inst.play(8);
    expect_rx(2, 2, 2, 0);
    $display("test rx gap done");
    wr(8'hb3, 32'h1);
    snap();
    tx_frame(pmcs_phy_model_inst.nibs.size(), 1'b1);
    expect_rx(1, 0, 0, 0);
    wr(8'hb3, 32'h0);
    snap();
    tx_frame(pmcs_phy_model_inst.nibs.size(), 1'b1);
    expect_rx(0, 0, 0, 0);
    $display("test loopback done");
    results();
  end
endmodule // tb_top
